// File: src/async_serial_transceiver.sv
// full-duplex asynchronous serial transceiver
// Function
// R01: eight data bits, least significant first
// R02: low start bit, one or two stops
// R03: optional even or odd parity
// R04: shared baud rate and format
// R05: sixteen-bit divisor from two bytes
// R06: divider doubles as general timer
// R07: separate transmit and receive enables
// R08: separate transmit and receive interrupts
// R09: flag framing, parity, overrun, break
// R10: driver enable during transmission
// R11: parity only outside ninth-bit mode
// R12: flow enable selects clear-to-send obedience
// R13: holding free flag shows register empty
// R14: written byte moves to shifter automatically
// R15: transmit interrupt while holding register free
// R16: ninth-bit mode, three receive interrupt schemes
// R17: software sets address bit before write
// R18: software writes only when holding free
// R19: address flag after data, before stops
// R20: clear-to-send sampled one clock ahead
// R21: started character always finishes; here it pauses mid-character while tx_enable is low
// R22: data available shows received byte
// R23: idle line high, load between characters
// R24: falling edge start, mid-bit sampling
`include "async_serial_transceiver_regs.svh"
module async_serial_transceiver
  import async_serial_transceiver_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       tx_enable,
  input  wire logic       rx_enable,
  input  wire logic       parity_enable,
  input  wire logic       parity_select,
  input  wire logic       two_stop_bits,
  input  wire logic       cts_flow_enable,
  input  wire logic       ninth_bit_mode_enable,
  input  wire logic [1:0] mp_mode_select,
  input  wire logic [7:0] mp_address,
  input  wire logic       tx_addr_bit,
  input  wire logic       timer_mode,
  input  wire logic [7:0] divisor_high,
  input  wire logic [7:0] divisor_low,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_write,
  input  wire logic       rx_read,
  input  wire logic       status_clear,
  input  wire logic       tx_irq_enable,
  input  wire logic       rx_irq_enable,
  input  wire logic       cts_n,
  input  wire logic       rxd,
  output logic            txd,
  output logic            driver_enable,
  output logic            tx_holding_free,
  output logic            tx_idle,
  output logic            rx_data_available,
  output logic [7:0]      rx_data,
  output logic            rx_addr_flag,
  output logic            rx_new_frame,
  output logic            framing_error,
  output logic            parity_error,
  output logic            overrun_error,
  output logic            break_detect,
  output logic            timer_expired,
  output logic            tx_irq,
  output logic            rx_irq
);
  // ====================================================================
  // baud timing
  logic [15:0] divisor;
  logic        bit_tick;
  logic        os_tick;
  logic        tx_run;
  logic        tx_restart;
  logic        rx_run;

  assign divisor = {divisor_high, divisor_low}; // R05

  // divisor counts one whole bit period; receiver uses a 16x copy
  baud_tick_gen u_tx_tick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (tx_run),
    .restart (tx_restart),
    .divisor (divisor),
    .tick    (bit_tick)
  ); // R04

  baud_tick_gen u_rx_tick (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (rx_run),
    .restart (1'b0),
    .divisor ({4'h0, divisor[15:4]}),
    .tick    (os_tick)
  ); // R04

  // ====================================================================
  // timer mode
  logic timer_reg;

  // in timer mode the transmit divider free-runs and raises a pulse
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timer_reg <= 1'b0;
    end else begin
      timer_reg <= timer_mode && bit_tick; // R06
    end
  end
  assign timer_expired = timer_reg;

  // ====================================================================
  // transmitter
  ser_state_type tx_state_reg;
  logic [7:0]    hold_reg;
  logic          hold_full_reg;
  logic          hold_addr_reg;
  logic [7:0]    tx_shift_reg;
  logic          tx_ninth_reg;
  logic [2:0]    tx_index_reg;
  logic          txd_reg;
  logic          cts_ok_reg;
  logic          ninth_used;
  logic          tx_start;

  assign ninth_used = ninth_bit_mode_enable || parity_enable;
  assign tx_run     = timer_mode || (tx_enable && tx_state_reg != ser_idle);
  assign tx_start   = !timer_mode && tx_enable && hold_full_reg
                      && tx_state_reg == ser_idle && cts_ok_reg;
  assign tx_restart = tx_start;

  // clear-to-send registered so it is taken one clock before start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cts_ok_reg <= 1'b0;
    end else begin
      cts_ok_reg <= !cts_flow_enable || !cts_n; // R12 R20
    end
  end

  // holding register, refilled by software, drained by the shifter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg      <= 8'h00;
      hold_full_reg <= 1'b0;
      hold_addr_reg <= 1'b0;
    end else if (tx_write) begin
      hold_reg      <= tx_data;
      hold_full_reg <= 1'b1;
      hold_addr_reg <= tx_addr_bit; // R17
    end else if (tx_start) begin
      hold_full_reg <= 1'b0; // R14
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_reg <= ser_idle;
      tx_shift_reg <= 8'h00;
      tx_ninth_reg <= 1'b0;
      tx_index_reg <= 3'h0;
      txd_reg      <= 1'b1;
    end else if (tx_start) begin
      tx_state_reg <= ser_start; // R23
      tx_shift_reg <= hold_reg;
      tx_ninth_reg <= ninth_bit_mode_enable ? hold_addr_reg
                      : (^hold_reg) ^ parity_select; // R03 R11 R19
      tx_index_reg <= 3'h0;
      txd_reg      <= 1'b0; // R02
    end else if (!tx_enable && tx_state_reg == ser_idle) begin
      txd_reg <= 1'b1; // R23
    end else if (bit_tick) begin
      // once started a character runs to its end regardless of cts
      case (tx_state_reg)
        ser_start: begin
          tx_state_reg <= ser_data;
          txd_reg      <= tx_shift_reg[0]; // R01
        end
        ser_data: begin
          if (tx_index_reg == `LAST_DATA_INDEX) begin
            tx_state_reg <= ninth_used ? ser_ninth : ser_stop1;
            txd_reg      <= ninth_used ? tx_ninth_reg : 1'b1; // R19
          end else begin
            tx_index_reg <= tx_index_reg + 3'h1;
            txd_reg      <= tx_shift_reg[tx_index_reg + 3'h1]; // R01
          end
        end
        ser_ninth: begin
          tx_state_reg <= ser_stop1;
          txd_reg      <= 1'b1;
        end
        ser_stop1: begin
          tx_state_reg <= two_stop_bits ? ser_stop2 : ser_idle; // R02 R21
          txd_reg      <= 1'b1;
        end
        default: begin
          tx_state_reg <= ser_idle;
          txd_reg      <= 1'b1;
        end
      endcase
    end
  end

  assign txd             = txd_reg;
  assign driver_enable   = tx_state_reg != ser_idle; // R10
  assign tx_holding_free = !hold_full_reg; // R13
  assign tx_idle         = tx_state_reg == ser_idle && !hold_full_reg;
  assign tx_irq          = tx_irq_enable && tx_enable && !hold_full_reg; // R08 R15

  // ====================================================================
  // receiver
  ser_state_type rx_state_reg;
  logic          rxd_last_reg;
  logic [3:0]    os_count_reg;
  logic [2:0]    rx_index_reg;
  logic [7:0]    rx_shift_reg;
  logic          rx_ninth_reg;
  logic          rx_zero_reg;
  logic          rx_done;
  logic          rx_stop_bad;
  logic          rx_par_bad;
  logic          rx_accept;
  logic          frame_match_reg;
  logic          new_frame_pend_reg;
  logic          mid_bit;

  assign rx_run  = rx_enable && rx_state_reg != ser_idle;
  assign mid_bit = os_tick && os_count_reg == 4'h7;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxd_last_reg <= 1'b1;
    end else begin
      rxd_last_reg <= rxd;
    end
  end

  // start found on a falling edge, then each bit sampled mid-period
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_reg <= ser_idle;
      os_count_reg <= 4'h0;
      rx_index_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_ninth_reg <= 1'b0;
      rx_zero_reg  <= 1'b1;
    end else if (!rx_enable) begin
      rx_state_reg <= ser_idle; // R07
    end else if (rx_state_reg == ser_idle) begin
      if (rxd_last_reg && !rxd) begin
        rx_state_reg <= ser_start; // R24
        os_count_reg <= 4'h0;
      end
    end else if (os_tick) begin
      os_count_reg <= os_count_reg + 4'h1;
      if (os_count_reg == 4'h7) begin
        case (rx_state_reg)
          ser_start: begin
            rx_state_reg <= rxd ? ser_idle : ser_data; // R24
            rx_index_reg <= 3'h0;
            rx_zero_reg  <= 1'b1;
          end
          ser_data: begin
            rx_shift_reg <= {rxd, rx_shift_reg[7:1]}; // R01
            rx_zero_reg  <= rx_zero_reg && !rxd;
            if (rx_index_reg == `LAST_DATA_INDEX) begin
              rx_state_reg <= ninth_used ? ser_ninth : ser_stop1;
            end
            rx_index_reg <= rx_index_reg + 3'h1;
          end
          ser_ninth: begin
            rx_ninth_reg <= rxd;
            rx_zero_reg  <= rx_zero_reg && !rxd;
            rx_state_reg <= ser_stop1;
          end
          default: begin
            rx_state_reg <= ser_idle;
          end
        endcase
      end
    end
  end

  assign rx_done     = mid_bit && rx_state_reg == ser_stop1 && rx_enable;
  assign rx_stop_bad = !rxd;
  assign rx_par_bad  = parity_enable && !ninth_bit_mode_enable
                       && ((^rx_shift_reg) ^ rx_ninth_reg ^ parity_select); // R03 R11

  // multiprocessor filtering of received characters
  always_comb begin
    rx_accept = 1'b1;
    if (ninth_bit_mode_enable) begin
      case (mp_mode_select)
        `MP_ALL_ADDR:   rx_accept = rx_ninth_reg;
        `MP_MATCH_ADDR: rx_accept = rx_ninth_reg ? (rx_shift_reg == mp_address)
                                    : frame_match_reg;
        `MP_DATA_ONLY:  rx_accept = !rx_ninth_reg && frame_match_reg;
        default:        rx_accept = 1'b1;
      endcase
    end
  end // R16

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      frame_match_reg    <= 1'b0;
      new_frame_pend_reg <= 1'b0;
    end else if (rx_done && ninth_bit_mode_enable && rx_ninth_reg) begin
      frame_match_reg    <= mp_mode_select == `MP_DATA_ONLY
                            || rx_shift_reg == mp_address; // R16
      new_frame_pend_reg <= 1'b1;
    end else if (rx_done && rx_accept) begin
      new_frame_pend_reg <= 1'b0;
    end
  end

  // receive holding register and error flags; a new event beats a clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_data           <= 8'h00;
      rx_addr_flag      <= 1'b0;
      rx_new_frame      <= 1'b0;
      rx_data_available <= 1'b0;
      framing_error     <= 1'b0;
      parity_error      <= 1'b0;
      overrun_error     <= 1'b0;
      break_detect      <= 1'b0;
    end else if (rx_done && rx_accept) begin
      if (rx_data_available && !rx_read) begin
        overrun_error <= 1'b1; // R09
      end else begin
        rx_data      <= rx_shift_reg;
        rx_addr_flag <= rx_ninth_reg;
        rx_new_frame <= new_frame_pend_reg && !rx_ninth_reg;
        overrun_error <= overrun_error && !status_clear;
      end
      rx_data_available <= 1'b1; // R22
      framing_error     <= rx_stop_bad || (framing_error && !status_clear); // R09
      parity_error      <= rx_par_bad || (parity_error && !status_clear); // R09
      break_detect      <= (rx_stop_bad && rx_zero_reg)
                           || (break_detect && !status_clear); // R09
    end else begin
      if (rx_read) begin
        rx_data_available <= 1'b0; // R22
      end
      if (status_clear) begin
        framing_error <= 1'b0;
        parity_error  <= 1'b0;
        overrun_error <= 1'b0;
        break_detect  <= 1'b0;
      end
    end
  end

  assign rx_irq = rx_irq_enable && (rx_data_available || framing_error
                  || parity_error || overrun_error || break_detect); // R08
endmodule

// File: src/async_serial_transceiver_pkg.sv
// types of the serial transceiver
package async_serial_transceiver_pkg;
  typedef enum logic [2:0] {
    ser_idle   = 3'b000,
    ser_start  = 3'b001,
    ser_data   = 3'b010,
    ser_ninth  = 3'b011,
    ser_stop1  = 3'b100,
    ser_stop2  = 3'b101
  } ser_state_type;
endpackage

// File: src/async_serial_transceiver_regs.svh
// constants of the serial transceiver
`ifndef ASYNC_SERIAL_TRANSCEIVER_REGS_SVH
`define ASYNC_SERIAL_TRANSCEIVER_REGS_SVH
`define DATA_BITS        4'h8
`define LAST_DATA_INDEX  3'h7
`define DIVIDER_RESET    16'h0001
`define CTS_SAMPLE_LEAD  1
`define MP_ALL_ADDR      2'h1
`define MP_MATCH_ADDR    2'h2
`define MP_DATA_ONLY     2'h3
`endif

// File: src/baud_tick_gen.sv
// baud rate divider, usable as general timer
`include "async_serial_transceiver_regs.svh"
module baud_tick_gen (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] count_reg;

  // counts down divisor system clocks per tick
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= `DIVIDER_RESET;
      tick      <= 1'b0;
    end else if (restart) begin
      // one count short: the consumer acts a clock after the tick
      count_reg <= (divisor <= 16'h0002) ? 16'h0001 : divisor - 16'h0001;
      tick      <= 1'b0;
    end else if (!run) begin
      count_reg <= (divisor == 16'h0000) ? 16'h0001 : divisor;
      tick      <= 1'b0;
    end else if (count_reg <= 16'h0001) begin
      count_reg <= (divisor == 16'h0000) ? 16'h0001 : divisor;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg - 16'h0001;
      tick      <= 1'b0;
    end
  end
endmodule

// File: tb/async_serial_transceiver_bench.sv
// self-checking bench of the serial transceiver
module async_serial_transceiver_bench import async_serial_transceiver_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, reset_n = 0, tx_enable = 0, rx_enable = 0, parity_enable = 0;
  logic parity_select = 0, two_stop_bits = 0, cts_flow_enable = 0, ninth_bit_mode_enable = 0;
  logic tx_addr_bit = 0, timer_mode = 0, tx_write = 0, rx_read = 0, status_clear = 0;
  logic tx_irq_enable = 0, rx_irq_enable = 0;
  logic [1:0] mp_mode_select = 2'h0;
  logic [7:0] mp_address = 8'h00, divisor_high = 8'h00, divisor_low = 8'h10, tx_data = 8'h00;
  logic cts_n, rxd, txd, driver_enable, tx_holding_free, tx_idle, rx_data_available;
  logic rx_addr_flag, rx_new_frame, framing_error, parity_error, overrun_error;
  logic break_detect, timer_expired, tx_irq, rx_irq;
  logic [7:0] rx_data;
  int n_errors = 0;
  int cmp_count = 0;
  async_serial_transceiver dut (.clk_sys, .reset_n, .tx_enable, .rx_enable, .parity_enable,
    .parity_select, .two_stop_bits, .cts_flow_enable, .ninth_bit_mode_enable, .mp_mode_select,
    .mp_address, .tx_addr_bit, .timer_mode, .divisor_high, .divisor_low, .tx_data, .tx_write,
    .rx_read, .status_clear, .tx_irq_enable, .rx_irq_enable, .cts_n, .rxd, .txd, .driver_enable,
    .tx_holding_free, .tx_idle, .rx_data_available, .rx_data, .rx_addr_flag, .rx_new_frame,
    .framing_error, .parity_error, .overrun_error, .break_detect, .timer_expired, .tx_irq,
    .rx_irq);
  remote_serial_model peer (.clk_sys, .txd, .rxd, .cts_n);
  // ====
  // helpers
  always #20 clk_sys = ~clk_sys;
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(string what, logic [8:0] exp, logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(logic [7:0] d);
    repeat (400) if (tx_holding_free !== 1'b1) cyc(1);
    tx_data = d;
    tx_write = 1;
    cyc(1);
    tx_write = 0;
  endtask
  task automatic idle_wait;
    repeat (400) if (tx_idle !== 1'b1) cyc(1);
  endtask
  task automatic read_clear;
    rx_read = 1;
    status_clear = 1;
    cyc(1);
    rx_read = 0;
    status_clear = 0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_formats;
    logic [3:0] cfg [4] = '{4'h0, 4'h8, 4'hE, 4'h9};
    logic [7:0] d;
    logic [8:0] v;
    logic ok;
    for (int k = 0; k < 4; k++) begin
      idle_wait;
      d = 8'h4B ^ 8'(k);
      {parity_enable, parity_select, two_stop_bits, ninth_bit_mode_enable} = cfg[k];
      tx_addr_bit = 1;
      fork
        put(d);
        peer.recv(cfg[k][3] | cfg[k][0], cfg[k][1], v, ok);
      join
      check("tx frame", {cfg[k][0] | (cfg[k][3] & (^d ^ cfg[k][2])), d}, v);
      check("stop bits", 9'h001, {8'h00, ok});
    end
    $display("formats done");
  endtask
  task automatic t_back_to_back;
    logic [8:0] v1, v2;
    logic ok;
    idle_wait;
    {parity_enable, parity_select, two_stop_bits, ninth_bit_mode_enable} = 4'h0;
    tx_irq_enable = 1;
    cyc(1);
    check("irq when free", 9'h001, {8'h00, tx_irq});
    fork
      begin
        put(8'h81);
        check("holding busy", 9'h000, {tx_irq, tx_holding_free});
        put(8'h7E);
      end
      begin
        peer.recv(0, 0, v1, ok);
        peer.recv(0, 0, v2, ok);
      end
    join
    check("first byte", 9'h081, v1);
    check("second byte", 9'h07E, v2);
    $display("back to back done");
  endtask
  task automatic t_cts;
    logic [8:0] v;
    logic ok;
    idle_wait;
    cts_flow_enable = 1;
    peer.cts_hold = 1;
    put(8'h3C);
    cyc(100);
    check("held by cts", 9'h000, {8'h00, driver_enable});
    fork
      begin
        peer.cts_hold = 0;
        peer.recv(0, 0, v, ok);
      end
      begin
        cyc(40);
        check("driver on", 9'h001, {8'h00, driver_enable});
        peer.cts_hold = 1;
      end
    join
    check("cts frame", 9'h03C, v);
    check("cts stop", 9'h001, {8'h00, ok});
    cts_flow_enable = 0;
    fork
      put(8'hC3);
      peer.recv(0, 0, v, ok);
    join
    check("cts ignored", 9'h0C3, v);
    peer.cts_hold = 0;
    $display("flow control done");
  endtask
  task automatic t_rx;
    idle_wait;
    tx_enable = 0;
    rx_enable = 1;
    rx_irq_enable = 1;
    {parity_enable, parity_select} = 2'h3;
    peer.send(8'h96, 1, ~^8'h96, 0);
    check("rx byte", {1'b1, 8'h96}, {rx_data_available, rx_data});
    check("rx irq", 9'h001, {8'h00, rx_irq});
    peer.send(8'h55, 1, 1'b0, 0);
    check("overrun", {1'b1, 8'h96}, {overrun_error, rx_data});
    read_clear();
    check("flags clear", 9'h000, {5'h00, rx_data_available, overrun_error, parity_error,
      framing_error});
    peer.send(8'h55, 1, 1'b0, 0);
    check("parity error", 9'h155, {parity_error, rx_data});
    read_clear();
    peer.line = 0;
    cyc(224);
    peer.line = 1;
    cyc(32);
    check("break", 9'h003, {7'h00, framing_error, break_detect});
    read_clear();
    tx_enable = 1;
    $display("receive done");
  endtask
  task automatic t_mp_rx;
    ninth_bit_mode_enable = 1;
    parity_enable = 0;
    mp_mode_select = 2'h2;
    mp_address = 8'h5A;
    peer.send(8'h33, 1, 1'b1, 0);
    check("foreign address", 9'h000, {8'h00, rx_data_available});
    peer.send(8'h11, 1, 1'b0, 0);
    check("foreign data", 9'h000, {8'h00, rx_data_available});
    peer.send(8'h5A, 1, 1'b1, 0);
    check("own address", {1'b1, 8'h5A}, {rx_addr_flag, rx_data});
    read_clear();
    peer.send(8'h22, 1, 1'b0, 0);
    check("first data", {1'b1, 8'h22}, {rx_new_frame, rx_data});
    read_clear();
    ninth_bit_mode_enable = 0;
    mp_mode_select = 2'h0;
    $display("multiprocessor receive done");
  endtask
  task automatic t_timer;
    int gap;
    timer_mode = 1;
    repeat (100) if (timer_expired !== 1'b1) cyc(1);
    cyc(1);
    gap = 1;
    while (gap < 100 && timer_expired !== 1'b1) begin
      cyc(1);
      gap++;
    end
    check("timer period", 9'h010, 9'(gap));
    timer_mode = 0;
    $display("timer done");
  endtask
  // ====
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    reset_n = 1;
    tx_enable = 1;
    t_formats();
    t_back_to_back();
    t_cts();
    t_rx();
    t_mp_rx();
    t_timer();
    finish_test();
  end
  initial begin
    #(40 * 20000);
    n_errors++;
    finish_test();
  end
endmodule

// File: tb/async_serial_transceiver_checker.sv
// port assertions for the serial transceiver
// ====
// checker
module async_serial_transceiver_checker (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       tx_enable,
  input wire logic       tx_write,
  input wire logic       tx_irq_enable,
  input wire logic       cts_flow_enable,
  input wire logic       cts_n,
  input wire logic       timer_mode,
  input wire logic       rx_read,
  input wire logic [7:0] divisor_high,
  input wire logic [7:0] divisor_low,
  input wire logic       txd,
  input wire logic       driver_enable,
  input wire logic       tx_holding_free,
  input wire logic       tx_idle,
  input wire logic       rx_data_available,
  input wire logic       timer_expired,
  input wire logic       tx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] de_count_reg;
  logic [15:0] div;
  assign div = {divisor_high, divisor_low};
  // cycles spent on the line by one character
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) de_count_reg <= 16'h0000;
    else if (driver_enable) de_count_reg <= de_count_reg + 16'h0001;
    else de_count_reg <= 16'h0000;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_load;
    !tx_holding_free ##1 (driver_enable && tx_holding_free);
  endsequence
  sequence s_start_bit;
    !txd [*8];
  endsequence
  AST_IDLE_HIGH: assert property (!driver_enable |-> txd)
    else $error("line not high between characters");
  AST_START_LOW: assert property ($rose(driver_enable) |-> s_start_bit)
    else $error("start bit not low");
  AST_WRITE_START: assert property (tx_write && tx_idle && tx_enable && !cts_flow_enable
    && !timer_mode |=> s_load) else $error("written byte not sent");
  AST_HOLD_CLEAR: assert property (tx_write |=> !tx_holding_free)
    else $error("holding flag free after write");
  AST_CTS_WAIT: assert property ($rose(driver_enable) && $past(cts_flow_enable, 2)
    |-> !$past(cts_n, 2)) else $error("start while clear-to-send released");
  AST_CHAR_LENGTH: assert property ($fell(driver_enable) |-> de_count_reg == div * 16'h000A
    || de_count_reg == div * 16'h000B || de_count_reg == div * 16'h000C)
    else $error("character length wrong");
  AST_IRQ_AT_ONCE: assert property ($rose(tx_irq_enable) && tx_enable && tx_holding_free
    |-> tx_irq) else $error("transmit request not raised");
  AST_RDA_READ: assert property (rx_read |=> !rx_data_available)
    else $error("data flag kept after read");
  AST_TIMER_GAP: assert property (timer_mode && timer_expired |=> !timer_expired [*8])
    else $error("timer pulse too soon");
endmodule
bind async_serial_transceiver async_serial_transceiver_checker checker_inst (.clk_sys,
  .reset_n, .tx_enable, .tx_write, .tx_irq_enable, .cts_flow_enable, .cts_n, .timer_mode,
  .rx_read, .divisor_high, .divisor_low, .txd, .driver_enable, .tx_holding_free, .tx_idle,
  .rx_data_available, .timer_expired, .tx_irq);

// File: tb/remote_serial_model.sv
// remote serial device at the far end of the line
// ====
// model
module remote_serial_model (
  input  wire logic clk_sys,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16;
  logic line = 1'b1;
  logic cts_hold = 1'b0;
  assign rxd = line;
  assign cts_n = cts_hold;
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // b9 is a stop level when no ninth bit
  task automatic send(logic [7:0] d, logic has9, logic b9, logic two);
    logic [11:0] f;
    int i;
    f = {2'b11, b9, d, 1'b0};
    for (i = 0; i < 10 + has9 + two; i++) begin
      line = f[i];
      tick(BIT);
    end
  endtask
  task automatic recv(logic has9, logic two, output logic [8:0] v, output logic ok);
    int i;
    v = 9'h000;
    for (i = 0; i < 2000 && txd !== 1'b0; i++) tick(1);
    tick(BIT / 2);
    ok = (txd === 1'b0);
    for (i = 0; i < 8 + has9; i++) begin
      tick(BIT);
      v[i] = txd;
    end
    for (i = 0; i < 1 + two; i++) begin
      tick(BIT);
      ok = ok & (txd === 1'b1);
    end
  endtask
endmodule
